//--- common/pwr_seq_pkg.sv
// constants, register map and types of the power-on master clear sequencer
package pwr_seq_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SETTLE_MS = 300;
    localparam int unsigned CLEAR_MS = 150;
    localparam int unsigned DRIVE_HZ = 25_000;
    localparam int unsigned SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned CLEAR_CYCLES = CLEAR_MS * (CLK_HZ / 1000);
    localparam int unsigned DRIVE_HALF_CYCLES = CLK_HZ / (2 * DRIVE_HZ);
    localparam int unsigned TIMER_W = 32;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned REG_AW = 8;
    localparam int unsigned REG_DW = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVENT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;

    // control bits (write one, self clearing)
    localparam int unsigned CTRL_ON = 0;
    localparam int unsigned CTRL_OFF = 1;

    // status bits
    localparam int unsigned ST_LATCH = 0;
    localparam int unsigned ST_SETTLE = 1;
    localparam int unsigned ST_ARM = 2;
    localparam int unsigned ST_FAULT = 3;
    localparam int unsigned ST_MASTER_CLEAR_N_N = 4;
    localparam int unsigned ST_UV_SENSE = 5;
    localparam int unsigned ST_OV_N = 6;
    localparam int unsigned ST_PHASE = 8;

    // event bits, same layout in the mask register
    localparam int unsigned EV_W = 5;
    localparam int unsigned EV_ON = 0;
    localparam int unsigned EV_SETTLED = 1;
    localparam int unsigned EV_RELEASED = 2;
    localparam int unsigned EV_OV_TRIP = 3;
    localparam int unsigned EV_UV_TRIP = 4;

    localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
    localparam logic [REG_DW-1:0] RDATA_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PH_STANDBY = 2'b00,
        PH_SETTLE = 2'b01,
        PH_QUALIFY = 2'b11,
        PH_POWERED = 2'b10
    } phase_t;

    function automatic logic reg_hit(input logic [REG_AW-1:0] addr, input logic [REG_AW-1:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

endpackage : pwr_seq_pkg

//--- common/delay_if.sv
// start and expiry handshake between the sequencer and a delay timer
`timescale 1ns/10ps
interface delay_if;
    logic run;
    logic expired;

    modport ctrl
    (
        output run,
        input expired
    );

    modport timer
    (
        input run,
        output expired
    );
endinterface : delay_if

//--- logic/delay_timer.sv
// cycle counting delay that expires after COUNT cycles of run and holds
`timescale 1ns/10ps
module delay_timer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned COUNT = 1
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // control
    delay_if.timer dly
);

    logic [TIMER_W-1:0] count;
    logic at_end;

    // count never passes the end, so a held run keeps expired high
    assign at_end = (count == TIMER_W'(COUNT - 1));

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= '0;
            dly.expired <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!dly.run)
            begin
                count <= '0;
                dly.expired <= 1'b0;
            end
            else if (at_end)
                dly.expired <= 1'b1;
            else
                count <= count + TIMER_W'(1);
        end
    end

endmodule : delay_timer

//--- logic/drive_phase_gen.sv
// alternating phase a / phase b converter drive while not inhibited
`timescale 1ns/10ps
module drive_phase_gen
    import pwr_seq_pkg::*;
#(
    parameter int unsigned HALF = DRIVE_HALF_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // control
    input wire logic enable,
    // drive
    output logic drive_a,
    output logic drive_b
);

    logic [TIMER_W-1:0] count;
    logic phase;
    logic half_end;

    assign half_end = (count == TIMER_W'(HALF - 1));

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= '0;
            phase <= 1'b0;
            drive_a <= 1'b0;
            drive_b <= 1'b0;
        end
        else if (clk_en)
        begin
            count <= (!enable || half_end) ? '0 : count + TIMER_W'(1);
            phase <= !enable ? 1'b0 : (half_end ? ~phase : phase);
            drive_a <= enable && !phase;
            drive_b <= enable && phase;
        end
    end

endmodule : drive_phase_gen

//--- logic/power_on_master_clear_sequencer.sv
// power latch, settle delay, low voltage check and master clear sequencing
//
// Behaviour
// - latch reset holds converter inhibit high
// - power switch pulse sets the power latch
// - set latch drops inhibit, drive runs
// - latch starts 300 ms delay, then flag
// - flag clear forces arm latch reset
// - power-on enables under/over voltage detection
// - master clear low until three inputs high
// - master clear released 150 ms after qualifying
// - settle flag removes one master clear inhibit
// - released master clear lights powered indicator
// - latch reset lights standby indicator
// - abnormal supply shuts the converter down
// - overvoltage resets latch, full shutdown follows
// - armed undervoltage sets fault, resets latch
`timescale 1ns/10ps
module power_on_master_clear_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int unsigned SETTLE_COUNT = SETTLE_CYCLES,
    parameter int unsigned CLEAR_COUNT = CLEAR_CYCLES,
    parameter int unsigned DRIVE_HALF = DRIVE_HALF_CYCLES
)
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata,
    output logic irq,
    // pins from the switch and comparators
    input wire logic power_on_pulse,
    input wire logic undervolt_sense,
    input wire logic overvolt_ok_n,
    // converter
    output logic converter_inhibit,
    output logic drive_a,
    output logic drive_b,
    output logic detect_enable,
    // transport and panel
    output logic master_clear_n,
    output logic standby_led,
    output logic powered_led
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic press_prev;
    logic press;
    logic uv_ok;
    logic ov_pin_low;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_meta <= 3'h6;
            pin_sync <= 3'h6;
            press_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_meta <= {overvolt_ok_n, undervolt_sense, power_on_pulse};
            pin_sync <= pin_meta;
            press_prev <= pin_sync[0];
        end
    end

    // a long press counts once
    assign press = pin_sync[0] && !press_prev;
    assign uv_ok = pin_sync[1];
    assign ov_pin_low = !pin_sync[2];

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_mask;
    logic rd_event;
    logic sw_on;
    logic sw_off;

    assign wr_ctrl = reg_wr && reg_hit(reg_addr, OFS_CTRL);
    assign wr_mask = reg_wr && reg_hit(reg_addr, OFS_MASK);
    assign rd_event = reg_rd && reg_hit(reg_addr, OFS_EVENT);
    assign sw_on = wr_ctrl && reg_wdata[CTRL_ON];
    assign sw_off = wr_ctrl && reg_wdata[CTRL_OFF];

    // ------------------------------------------------------------
    // power latch and fault latches
    // ------------------------------------------------------------
    logic power_latch;
    logic undervolt_arm_latch;
    logic undervolt_fault_latch;
    logic settle_delay_flag;
    logic start_req;
    logic ov_trip;
    logic uv_trip;
    logic latch_off;
    logic next_power_latch;
    logic next_arm;
    logic next_fault;

    assign start_req = press || sw_on;
    // comparators only count while the supply is up
    assign detect_enable = power_latch;
    assign ov_trip = detect_enable && ov_pin_low;
    assign uv_trip = settle_delay_flag && !uv_ok;
    // a new start clears an old low voltage fault; overvoltage still blocks it
    assign latch_off = ov_trip || (ov_pin_low && start_req) || sw_off ||
                       (undervolt_fault_latch && !start_req);
    assign next_power_latch = latch_off ? 1'b0 : (start_req ? 1'b1 : power_latch);

    assign next_arm = !settle_delay_flag ? 1'b0 : (undervolt_arm_latch || uv_trip);
    assign next_fault = start_req ? 1'b0 :
                        (undervolt_fault_latch || undervolt_arm_latch);

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_latch <= 1'b0;
            undervolt_arm_latch <= 1'b0;
            undervolt_fault_latch <= 1'b0;
        end
        else if (clk_en)
        begin
            power_latch <= next_power_latch;
            undervolt_arm_latch <= next_arm;
            undervolt_fault_latch <= next_fault;
        end
    end

    // ------------------------------------------------------------
    // converter inhibit and drive
    // ------------------------------------------------------------
    assign converter_inhibit = !power_latch;

    drive_phase_gen #(
        .HALF(DRIVE_HALF)
    ) u_drive (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(!converter_inhibit),
        .drive_a(drive_a),
        .drive_b(drive_b)
    );

    // ------------------------------------------------------------
    // settle delay and master clear delay
    // ------------------------------------------------------------
    delay_if settle_dly ();
    delay_if clear_dly ();
    logic qualify;

    // counters restart from zero whenever the latch drops
    assign settle_dly.run = power_latch;
    assign settle_delay_flag = settle_dly.expired;

    // the flag is one of three inhibits, the latch and sense the others
    assign qualify = power_latch && uv_ok && settle_delay_flag;
    assign clear_dly.run = qualify;

    delay_timer #(
        .COUNT(SETTLE_COUNT)
    ) u_settle (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .dly(settle_dly.timer)
    );

    delay_timer #(
        .COUNT(CLEAR_COUNT)
    ) u_clear (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .dly(clear_dly.timer)
    );

    // ------------------------------------------------------------
    // outputs to transport and panel
    // ------------------------------------------------------------
    // gated by qualify so a trip pulls master clear low at once
    logic released;

    assign released = qualify && clear_dly.expired;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            master_clear_n <= 1'b0;
            powered_led <= 1'b0;
            standby_led <= 1'b1;
        end
        else if (clk_en)
        begin
            master_clear_n <= released;
            powered_led <= released;
            // current limiting is the board's job; this only switches it
            standby_led <= !next_power_latch;
        end
    end

    // ------------------------------------------------------------
    // sequence phase
    // ------------------------------------------------------------
    phase_t phase;
    phase_t next_phase;

    always_comb
    begin
        next_phase = phase;
        unique case (phase)
            PH_STANDBY:
                if (power_latch)
                    next_phase = PH_SETTLE;
            PH_SETTLE:
                if (!power_latch)
                    next_phase = PH_STANDBY;
                else if (settle_delay_flag)
                    next_phase = PH_QUALIFY;
            PH_QUALIFY:
                if (!power_latch)
                    next_phase = PH_STANDBY;
                else if (master_clear_n)
                    next_phase = PH_POWERED;
            PH_POWERED:
                if (!power_latch)
                    next_phase = PH_STANDBY;
                else if (!master_clear_n)
                    next_phase = PH_QUALIFY;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            phase <= PH_STANDBY;
        else if (clk_en)
            phase <= next_phase;
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic settle_prev;
    logic master_clear_n_prev;
    logic latch_prev;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] next_events;

    assign ev_set[EV_ON] = power_latch && !latch_prev;
    assign ev_set[EV_SETTLED] = settle_delay_flag && !settle_prev;
    assign ev_set[EV_RELEASED] = master_clear_n && !master_clear_n_prev;
    assign ev_set[EV_OV_TRIP] = ov_trip;
    assign ev_set[EV_UV_TRIP] = undervolt_arm_latch && !undervolt_fault_latch;

    // a new event in the reading cycle survives the clear
    assign next_events = (rd_event ? '0 : events) | ev_set;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            latch_prev <= 1'b0;
            settle_prev <= 1'b0;
            master_clear_n_prev <= 1'b0;
            events <= '0;
            mask <= MASK_RESET;
        end
        else if (clk_en)
        begin
            latch_prev <= power_latch;
            settle_prev <= settle_delay_flag;
            master_clear_n_prev <= master_clear_n;
            events <= next_events;
            if (wr_mask)
                mask <= reg_wdata[EV_W-1:0];
        end
    end

    assign irq = |(events & mask);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [REG_DW-1:0] status_word;
    logic [REG_DW-1:0] read_mux;

    always_comb
    begin
        status_word = '0;
        status_word[ST_LATCH] = power_latch;
        status_word[ST_SETTLE] = settle_delay_flag;
        status_word[ST_ARM] = undervolt_arm_latch;
        status_word[ST_FAULT] = undervolt_fault_latch;
        status_word[ST_MASTER_CLEAR_N_N] = master_clear_n;
        status_word[ST_UV_SENSE] = uv_ok;
        status_word[ST_OV_N] = !ov_pin_low;
        status_word[ST_PHASE +: 2] = phase;
    end

    // control reads as zero: its bits act only on the write
    assign read_mux = reg_hit(reg_addr, OFS_STATUS) ? status_word :
                      reg_hit(reg_addr, OFS_EVENT) ? REG_DW'(events) :
                      reg_hit(reg_addr, OFS_MASK) ? REG_DW'(mask) : '0;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= RDATA_RESET;
        else if (clk_en)
            reg_rdata <= reg_rd ? read_mux : RDATA_RESET;
    end

endmodule : power_on_master_clear_sequencer

//--- test/supply_model.sv
// converter, comparator and load model facing the sequencer
`timescale 1ns/10ps
module supply_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // from the sequencer
    input wire logic converter_inhibit,
    input wire logic drive_a,
    input wire logic drive_b,
    // fault injection
    input wire logic uv_fault,
    input wire logic ov_fault,
    // comparators
    output logic undervolt_sense,
    output logic overvolt_ok_n
);
    logic [2:0] ramp;

    // undervolt_sense comes up only after some drive, never at the instant of enable; overvolt_ok_n follows only ov_fault
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            ramp <= 3'h0;
        else if (converter_inhibit)
            ramp <= 3'h0;
        else
            ramp <= {ramp[1:0], drive_a | drive_b};
    end

    assign undervolt_sense = ramp[2] & ~uv_fault;
    assign overvolt_ok_n = ~ov_fault;
endmodule : supply_model

//--- test/seq_chk.sv
// port checker of the power-on master clear sequencer
`timescale 1ns/10ps
module seq_chk
    import pwr_seq_pkg::*;
#(
    parameter int unsigned SETTLE_COUNT = 20,
    parameter int unsigned CLEAR_COUNT = 10
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // watched ports
    input wire logic reg_rd,
    input wire logic [REG_DW-1:0] reg_rdata,
    input wire logic undervolt_sense,
    input wire logic overvolt_ok_n,
    input wire logic converter_inhibit,
    input wire logic drive_a,
    input wire logic drive_b,
    input wire logic detect_enable,
    input wire logic master_clear_n,
    input wire logic standby_led,
    input wire logic powered_led
);
    logic [31:0] on_cnt;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // saturating count of cycles with the converter running
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            on_cnt <= 32'h00000000;
        else if (converter_inhibit)
            on_cnt <= 32'h00000000;
        else if (on_cnt != 32'hFFFFFFFF)
            on_cnt <= on_cnt + 32'h00000001;
    end

    sequence ov_held;
        !overvolt_ok_n [*5];
    endsequence

    sequence shut_down;
        converter_inhibit ##1 !master_clear_n;
    endsequence

    a_inhibit_standby: assert property (converter_inhibit == standby_led)
        else $error("inhibit and standby indicator disagree");
    a_detect_power: assert property (detect_enable == !converter_inhibit)
        else $error("detection enable does not follow power");
    a_drive_off: assert property (converter_inhibit && $past(converter_inhibit) |->
        !drive_a && !drive_b) else $error("drive while inhibited");
    a_drive_alt: assert property (!(drive_a && drive_b))
        else $error("both drive phases high");
    a_drive_start: assert property ($fell(converter_inhibit) |->
        ##[1:3] (drive_a || drive_b)) else $error("drive did not start");
    a_ov_trip: assert property (ov_held |-> shut_down)
        else $error("overvoltage did not shut down");
    a_master_clear_n_drop: assert property (converter_inhibit |=> !master_clear_n)
        else $error("master clear released while powered down");
    a_master_clear_n_sense: assert property ($rose(master_clear_n) |-> $past(undervolt_sense, 3))
        else $error("master clear released without good voltage");
    a_master_clear_n_delay: assert property ($rose(master_clear_n) |->
        on_cnt >= SETTLE_COUNT + CLEAR_COUNT) else $error("master clear released early");
    a_powered_led: assert property (powered_led == master_clear_n)
        else $error("powered indicator wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read cycle");
endmodule : seq_chk

bind power_on_master_clear_sequencer seq_chk #(
    .SETTLE_COUNT(SETTLE_COUNT),
    .CLEAR_COUNT(CLEAR_COUNT)
) u_chk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .undervolt_sense(undervolt_sense),
    .overvolt_ok_n(overvolt_ok_n),
    .converter_inhibit(converter_inhibit),
    .drive_a(drive_a),
    .drive_b(drive_b),
    .detect_enable(detect_enable),
    .master_clear_n(master_clear_n),
    .standby_led(standby_led),
    .powered_led(powered_led)
);

//--- test/tb_top.sv
// self-checking bench of the power-on master clear sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
    import pwr_seq_pkg::*;
;
    // short counts keep the run small
    localparam int unsigned SC = 20;
    localparam int unsigned CC = 10;
    localparam int unsigned DH = 4;
    logic clk_sys;
    logic sys_rst;
    logic clk_en;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [REG_DW-1:0] reg_rdata;
    logic irq;
    logic power_on_pulse;
    logic uv_fault;
    logic ov_fault;
    logic undervolt_sense;
    logic overvolt_ok_n;
    logic converter_inhibit;
    logic drive_a;
    logic drive_b;
    logic detect_enable;
    logic master_clear_n;
    logic standby_led;
    logic powered_led;
    logic [31:0] rv;
    int err_total;
    int n_tests;
    int n;
    int t0;
    int cyc_cnt = 0;

    power_on_master_clear_sequencer #(.SETTLE_COUNT(SC), .CLEAR_COUNT(CC), .DRIVE_HALF(DH)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .power_on_pulse(power_on_pulse),
        .undervolt_sense(undervolt_sense), .overvolt_ok_n(overvolt_ok_n),
        .converter_inhibit(converter_inhibit), .drive_a(drive_a), .drive_b(drive_b),
        .detect_enable(detect_enable), .master_clear_n(master_clear_n),
        .standby_led(standby_led), .powered_led(powered_led));

    supply_model u_supply (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .converter_inhibit(converter_inhibit),
        .drive_a(drive_a), .drive_b(drive_b), .uv_fault(uv_fault), .ov_fault(ov_fault),
        .undervolt_sense(undervolt_sense), .overvolt_ok_n(overvolt_ok_n));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) cyc_cnt <= cyc_cnt + 1;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task end_sim;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask : end_sim

    task cyc(input int k);
    begin
        repeat (k) @(posedge clk_sys);
        #1;
    end
    endtask : cyc

    task wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    end
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    end
    endtask : rd

    task chk_rd(input logic [7:0] a, input logic [31:0] e);
    begin
        rd(a, rv);
        `CHK("read", e, rv)
    end
    endtask : chk_rd

    task press;
    begin
        @(posedge clk_sys);
        power_on_pulse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        power_on_pulse <= 1'b0;
        #1;
    end
    endtask : press

    function automatic logic sel(input int k);
        case (k)
            0: sel = converter_inhibit;
            1: sel = !converter_inhibit;
            default: sel = master_clear_n;
        endcase
    endfunction : sel

    // bounded wait; a timeout ends the run
    task wait_on(input int k, input int lim);
    begin
        n = 0;
        while (sel(k) !== 1'b1 && n < lim)
        begin
            cyc(1);
            n++;
        end
        if (n >= lim)
        begin
            err_total++;
            $display("[FAIL] wait %0d exp 1 got 0", k);
            end_sim();
        end
    end
    endtask : wait_on

    // power up from the latch set to master clear release
    task full_on;
    begin
        wait_on(1, 8);
        t0 = cyc_cnt;
        `CHK("standby", 1'b0, standby_led)
        `CHK("detect", 1'b1, detect_enable)
        rd(OFS_STATUS, rv);
        `CHK("settle early", 1'b0, rv[ST_SETTLE])
        `CHK("arm held", 1'b0, rv[ST_ARM])
        cyc(SC + 4 - (cyc_cnt - t0));
        rd(OFS_STATUS, rv);
        `CHK("settle late", 1'b1, rv[ST_SETTLE])
        `CHK("master_clear_n held", 1'b0, rv[ST_MASTER_CLEAR_N_N])
        wait_on(2, 40);
        n = cyc_cnt - t0;
        `CHK("master_clear_n delay", 1'b1, n >= SC + CC && n <= SC + CC + 3)
        `CHK("powered", 1'b1, powered_led)
    end
    endtask : full_on

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        power_on_pulse = 1'b0;
        uv_fault = 1'b0;
        ov_fault = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc(2);
        `CHK("inhibit", 1'b1, converter_inhibit)
        `CHK("master_clear_n", 1'b0, master_clear_n)
        chk_rd(OFS_MASK, 32'h00000000);
        chk_rd(OFS_STATUS, 32'h00000040);
        wr(8'h10, 32'hFFFFFFFF);
        chk_rd(8'h10, 32'h00000000);
        wr(OFS_MASK, 32'hFFFFFFFF);
        chk_rd(OFS_MASK, 32'h0000001F);
        press();
        full_on();
        `CHK("irq", 1'b1, irq)
        chk_rd(OFS_STATUS, 32'h00000273);
        chk_rd(OFS_EVENT, 32'h00000007);
        `CHK("irq clear", 1'b0, irq)
        rv = 0;
        repeat (40)
        begin
            t0 = drive_a;
            cyc(1);
            if (drive_a && !t0)
                rv++;
        end
        `CHK("drive rate", 40 / (2 * DH), rv)
        // armed undervoltage trips the supply
        @(posedge clk_sys);
        uv_fault <= 1'b1;
        wait_on(0, 12);
        cyc(1);
        `CHK("uv master_clear_n", 1'b0, master_clear_n)
        rd(OFS_STATUS, rv);
        `CHK("uv fault", 1'b1, rv[ST_FAULT])
        rd(OFS_EVENT, rv);
        `CHK("uv event", 1'b1, rv[EV_UV_TRIP])
        uv_fault <= 1'b0;
        // undervoltage inside the settle window is ignored
        wr(OFS_CTRL, 32'h00000001);
        wait_on(1, 4);
        @(posedge clk_sys);
        uv_fault <= 1'b1;
        cyc(5);
        uv_fault <= 1'b0;
        rd(OFS_STATUS, rv);
        `CHK("uv early", 1'b0, rv[ST_FAULT] | converter_inhibit)
        wait_on(2, 60);
        // overvoltage trips, then a press is refused
        @(posedge clk_sys);
        ov_fault <= 1'b1;
        wait_on(0, 8);
        press();
        cyc(6);
        `CHK("ov press", 1'b1, converter_inhibit)
        rd(OFS_EVENT, rv);
        `CHK("ov event", 1'b1, rv[EV_OV_TRIP])
        ov_fault <= 1'b0;
        cyc(3);
        // stop wins over start; a stop mid-settle restarts the delays
        wr(OFS_CTRL, 32'h00000003);
        cyc(3);
        `CHK("stop wins", 1'b1, converter_inhibit)
        wr(OFS_CTRL, 32'h00000001);
        cyc(SC - 4);
        wr(OFS_CTRL, 32'h00000002);
        cyc(2);
        `CHK("stopped", 1'b1, converter_inhibit)
        wr(OFS_MASK, 32'h00000000);
        rd(OFS_EVENT, rv);
        wr(OFS_CTRL, 32'h00000001);
        full_on();
        `CHK("masked", 1'b0, irq)
        wr(OFS_MASK, 32'h00000001);
        `CHK("unmasked", 1'b1, irq)
        rd(OFS_EVENT, rv);
        cyc(1);
        `CHK("read clears", 1'b0, irq)
        // a stop written while frozen must not be taken
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(OFS_CTRL, 32'h00000002);
        `CHK("frozen", 1'b0, converter_inhibit)
        @(posedge clk_sys);
        clk_en <= 1'b1;
        end_sim();
    end
endmodule : tb_top
